// *** core/pth_pkg.sv ***
// package for the print timing and head drive block: constants, types and register map
package pth_pkg;

  // timing base
  localparam logic [1:0] PTH_BIT_LAST = 2'h3;
  localparam logic [3:0] PTH_DIGIT_LAST = 4'hc;
  localparam logic [3:0] PTH_ROW_LAST = 4'h4;
  localparam logic [3:0] PTH_SLOT_LAST = 4'h8;
  localparam int PTH_POINT_DIGITS = 13;
  localparam int PTH_GLYPH_BITS = 20;
  localparam int PTH_GLYPH_COUNT = 32;

  // timing command encodings from the controller
  typedef enum logic [3:0] {
    PTH_CMD_IDLE = 4'h0,
    PTH_CMD_CHAR_STEP = 4'h1,
    PTH_CMD_PRINT_COUNT = 4'h2,
    PTH_CMD_POINT_SHIFT = 4'h3,
    PTH_CMD_CONTROL_STEP = 4'h4,
    PTH_CMD_PRINT = 4'h5
  } pth_cmd_t;

  // glyph index is {numeric flag, code}
  localparam logic [4:0] PTH_IDX_FIVE = 5'h15;
  localparam logic [4:0] PTH_IDX_SIX = 5'h16;
  localparam logic [4:0] PTH_IDX_E = 5'h0e;
  // row one in the top nibble, column one in each nibble's msb
  localparam logic [19:0] PTH_GLYPH_FIVE = 20'hf8e1e;
  localparam logic [19:0] PTH_GLYPH_SIX = 20'h68e96;
  localparam logic [19:0] PTH_GLYPH_E = 20'hf8e8f;

  // register byte offsets
  localparam logic [7:0] PTH_REG_CTRL = 8'h00;
  localparam logic [7:0] PTH_REG_STATUS = 8'h04;
  localparam logic [7:0] PTH_REG_CHAR_STEP = 8'h08;
  localparam logic [7:0] PTH_REG_PRINT_COUNT = 8'h0c;
  localparam logic [7:0] PTH_REG_POINT = 8'h10;
  localparam logic [7:0] PTH_REG_TIMEBASE = 8'h14;
  localparam logic [7:0] PTH_REG_GLYPH_INDEX = 8'h18;
  localparam logic [7:0] PTH_REG_GLYPH_DATA = 8'h1c;

  // field positions and reset values
  localparam int PTH_CTRL_HEAD_EN = 0;
  localparam int PTH_STAT_NUMERIC = 0;
  localparam int PTH_STAT_PRINTING = 1;
  localparam int PTH_STAT_CMD_LSB = 4;
  localparam int PTH_TB_DIGIT_LSB = 4;
  localparam int PTH_TB_SECTOR = 8;
  localparam logic PTH_CTRL_HEAD_EN_RESET = 1'b1;
  localparam logic [12:0] PTH_POINT_RESET = 13'h0001;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } pth_wb_req_t;

  typedef struct packed {
    logic charStep;
    logic printCount;
    logic pointShift;
    logic controlStep;
    logic printStrobe;
  } pth_pulses_t;

  typedef struct packed {
    logic numeric;
    logic [3:0] code;
  } pth_entry_t;

endpackage

// *** core/pth_sync.sv ***
// two-flop synchroniser for pins arriving from the controller and data chips
`timescale 1ns/100ps
module pth_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // asynchronous in, synchronous out
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1_q;
  logic [WIDTH-1:0] stage2_q;

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      stage1_q <= '0;
      stage2_q <= '0;
    end else begin
      stage1_q <= asyncIn;
      stage2_q <= stage1_q;
    end
  end

  assign syncOut = stage2_q;

endmodule

// *** core/pth_glyph_decoder.sv ***
// glyph decoder: fixed glyphs for five, six and E plus a writable table for the rest
`timescale 1ns/100ps
module pth_glyph_decoder (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // table write port
  input wire logic writeEnable,
  input wire logic [4:0] writeIndex,
  input wire logic [19:0] writeGlyph,
  // print lookup
  input wire logic [4:0] printIndex,
  output logic [19:0] printGlyph,
  // bus lookup
  input wire logic [4:0] busIndex,
  output logic [19:0] busGlyph
);

  logic [19:0] table_q [pth_pkg::PTH_GLYPH_COUNT];
  logic [19:0] table_d [pth_pkg::PTH_GLYPH_COUNT];

  function automatic logic [19:0] lookup(input logic [4:0] idx, input logic [19:0] stored);
    case (idx)
      pth_pkg::PTH_IDX_FIVE: lookup = pth_pkg::PTH_GLYPH_FIVE;
      pth_pkg::PTH_IDX_SIX: lookup = pth_pkg::PTH_GLYPH_SIX;
      pth_pkg::PTH_IDX_E: lookup = pth_pkg::PTH_GLYPH_E;
      default: lookup = stored;
    endcase
  endfunction

  always_comb begin
    table_d = table_q;
    if (writeEnable) begin
      table_d[writeIndex] = writeGlyph;
    end
  end

  // blank glyphs after reset so nothing heats on an unset code
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      for (int i = 0; i < pth_pkg::PTH_GLYPH_COUNT; i++) begin
        table_q[i] <= 20'h00000;
      end
    end else begin
      table_q <= table_d;
    end
  end

  assign printGlyph = lookup(printIndex, table_q[printIndex]);
  assign busGlyph = lookup(busIndex, table_q[busIndex]);

endmodule

// *** core/pth_print_timing.sv ***
// print timing and thermal head drive top: timing base, matrix, counters, head drive, wishbone slave
`timescale 1ns/100ps
module pth_print_timing (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // wishbone slave
  input wire pth_pkg::pth_wb_req_t wbReq,
  output logic wbAck,
  output logic [31:0] wbDatOut,
  // controller and data chip pins
  input wire logic [3:0] timingCommand,
  input wire pth_pkg::pth_entry_t entryRegister,
  // outputs to controller
  output pth_pkg::pth_pulses_t shiftPulses,
  output logic pointAtZero,
  output logic pointAtFour,
  // thermal head
  output logic [3:0] headColumnDrive,
  output logic [3:0] rowTimeSlot
);

  // synchronised pins
  logic [3:0] cmdSync;
  pth_pkg::pth_entry_t entrySync;

  pth_sync #(.WIDTH(4)) u_cmdSync (
    .clock(clock),
    .reset(reset),
    .asyncIn(timingCommand),
    .syncOut(cmdSync)
  );

  pth_sync #(.WIDTH(5)) u_entrySync (
    .clock(clock),
    .reset(reset),
    .asyncIn(entryRegister),
    .syncOut(entrySync)
  );

  // timing base
  logic [1:0] bitCounter_q, bitCounter_d;
  logic [3:0] digitCounter_q, digitCounter_d;
  logic sectorCounter_q, sectorCounter_d;
  logic wordEnd;

  assign wordEnd = (bitCounter_q == pth_pkg::PTH_BIT_LAST) && (digitCounter_q == pth_pkg::PTH_DIGIT_LAST);

  always_comb begin
    bitCounter_d = bitCounter_q + 2'h1;
    digitCounter_d = digitCounter_q;
    sectorCounter_d = sectorCounter_q;
    if (bitCounter_q == pth_pkg::PTH_BIT_LAST) begin
      digitCounter_d = (digitCounter_q == pth_pkg::PTH_DIGIT_LAST) ? 4'h0 : digitCounter_q + 4'h1;
      if (digitCounter_q == pth_pkg::PTH_DIGIT_LAST) begin
        sectorCounter_d = ~sectorCounter_q;
      end
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bitCounter_q <= 2'h0;
      digitCounter_q <= 4'h0;
      sectorCounter_q <= 1'b0;
    end else begin
      bitCounter_q <= bitCounter_d;
      digitCounter_q <= digitCounter_d;
      sectorCounter_q <= sectorCounter_d;
    end
  end

  // timing matrix; one pulse per word so each step is one count
  pth_pkg::pth_pulses_t pulses_d, pulses_q;
  logic printing;
  logic inSlot;

  assign printing = (cmdSync == pth_pkg::PTH_CMD_PRINT);
  assign inSlot = printing && (digitCounter_q <= pth_pkg::PTH_SLOT_LAST);

  always_comb begin
    pulses_d = '0;
    if (wordEnd) begin
      unique case (pth_pkg::pth_cmd_t'(cmdSync))
        pth_pkg::PTH_CMD_CHAR_STEP: pulses_d.charStep = 1'b1;
        pth_pkg::PTH_CMD_PRINT_COUNT: pulses_d.printCount = 1'b1;
        pth_pkg::PTH_CMD_POINT_SHIFT: pulses_d.pointShift = 1'b1;
        pth_pkg::PTH_CMD_CONTROL_STEP: pulses_d.controlStep = 1'b1;
        pth_pkg::PTH_CMD_PRINT: begin
          pulses_d.charStep = 1'b1;
          pulses_d.printCount = 1'b1;
        end
        default: pulses_d = '0;
      endcase
    end
    pulses_d.printStrobe = inSlot;
  end

  // counters and point register, stepped only by their pulses
  logic [4:0] charStep_q, charStep_d;
  logic [9:0] printCount_q, printCount_d;
  logic [12:0] point_q, point_d;

  always_comb begin
    charStep_d = charStep_q;
    printCount_d = printCount_q;
    point_d = point_q;
    if (pulses_d.charStep) begin
      charStep_d = charStep_q + 5'h01;
    end
    if (pulses_d.printCount) begin
      printCount_d = printCount_q + 10'h001;
    end
    if (pulses_d.pointShift) begin
      point_d = {point_q[11:0], point_q[12]};
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pulses_q <= '0;
      charStep_q <= 5'h00;
      printCount_q <= 10'h000;
      point_q <= pth_pkg::PTH_POINT_RESET;
    end else begin
      pulses_q <= pulses_d;
      charStep_q <= charStep_d;
      printCount_q <= printCount_d;
      point_q <= point_d;
    end
  end

  // glyph capture and head drive
  logic printing_q;
  logic [4:0] glyphIndex_q, glyphIndex_d;
  logic numericClass_q, numericClass_d;
  logic [3:0] head_d, head_q;
  logic [3:0] slot_d, slot_q;
  logic pointZero_q, pointFour_q;
  logic [19:0] printGlyph;
  logic [19:0] busGlyph;
  logic headEnable_q, headEnable_d;
  logic [4:0] busIndex_q, busIndex_d;
  logic glyphWrite;
  logic [19:0] glyphWriteData;

  always_comb begin
    glyphIndex_d = glyphIndex_q;
    numericClass_d = numericClass_q;
    // code taken as print starts; the glyph index is registered, so the new glyph reaches the head one cycle later
    if (printing && !printing_q) begin
      glyphIndex_d = {entrySync.numeric, entrySync.code};
      numericClass_d = entrySync.numeric;
    end
  end

  always_comb begin
    head_d = 4'h0;
    slot_d = 4'h0;
    if (inSlot) begin
      slot_d = digitCounter_q + 4'h1;
    end
    if (inSlot && headEnable_q && digitCounter_q <= pth_pkg::PTH_ROW_LAST) begin
      head_d = printGlyph[19 - 4 * digitCounter_q -: 4];
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      printing_q <= 1'b0;
      glyphIndex_q <= 5'h00;
      numericClass_q <= 1'b0;
      head_q <= 4'h0;
      slot_q <= 4'h0;
      pointZero_q <= 1'b1;
      pointFour_q <= 1'b0;
    end else begin
      printing_q <= printing;
      glyphIndex_q <= glyphIndex_d;
      numericClass_q <= numericClass_d;
      head_q <= head_d;
      slot_q <= slot_d;
      pointZero_q <= point_d[0];
      pointFour_q <= point_d[4];
    end
  end

  pth_glyph_decoder u_glyph (
    .clock(clock),
    .reset(reset),
    .writeEnable(glyphWrite),
    .writeIndex(busIndex_q),
    .writeGlyph(glyphWriteData),
    .printIndex(glyphIndex_q),
    .printGlyph(printGlyph),
    .busIndex(busIndex_q),
    .busGlyph(busGlyph)
  );

  // wishbone slave: ack one cycle after the request, dropped the next
  logic ack_q, ack_d;
  logic [31:0] datOut_q, datOut_d;
  logic access;
  logic wrAccess;
  logic [31:0] glyphMerged;

  function automatic logic [31:0] mergeLanes(input logic [31:0] old, input logic [31:0] data, input logic [3:0] sel);
    for (int i = 0; i < 4; i++) begin
      mergeLanes[8*i +: 8] = sel[i] ? data[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  assign access = wbReq.cyc && wbReq.stb && !ack_q;
  assign wrAccess = access && wbReq.we;
  assign glyphWrite = wrAccess && (wbReq.adr == pth_pkg::PTH_REG_GLYPH_DATA);
  // a function result cannot be part-selected, so the merged word is held first
  assign glyphMerged = mergeLanes({12'h000, busGlyph}, wbReq.dat, wbReq.sel);
  assign glyphWriteData = glyphMerged[19:0];

  always_comb begin
    logic [31:0] ctrlWord;
    logic [31:0] idxWord;
    logic [31:0] ctrlMerged;
    logic [31:0] idxMerged;
    ctrlWord = {31'h00000000, headEnable_q};
    idxWord = {27'h0000000, busIndex_q};
    ctrlMerged = mergeLanes(ctrlWord, wbReq.dat, wbReq.sel);
    idxMerged = mergeLanes(idxWord, wbReq.dat, wbReq.sel);
    headEnable_d = headEnable_q;
    busIndex_d = busIndex_q;
    if (wrAccess && wbReq.adr == pth_pkg::PTH_REG_CTRL) begin
      headEnable_d = ctrlMerged[pth_pkg::PTH_CTRL_HEAD_EN];
    end
    if (wrAccess && wbReq.adr == pth_pkg::PTH_REG_GLYPH_INDEX) begin
      busIndex_d = idxMerged[4:0];
    end
  end

  always_comb begin
    ack_d = access;
    datOut_d = 32'h00000000;
    if (access && !wbReq.we) begin
      case (wbReq.adr)
        pth_pkg::PTH_REG_CTRL: datOut_d[pth_pkg::PTH_CTRL_HEAD_EN] = headEnable_q;
        pth_pkg::PTH_REG_STATUS: begin
          datOut_d[pth_pkg::PTH_STAT_NUMERIC] = numericClass_q;
          datOut_d[pth_pkg::PTH_STAT_PRINTING] = printing_q;
          datOut_d[pth_pkg::PTH_STAT_CMD_LSB +: 4] = cmdSync;
        end
        pth_pkg::PTH_REG_CHAR_STEP: datOut_d[4:0] = charStep_q;
        pth_pkg::PTH_REG_PRINT_COUNT: datOut_d[9:0] = printCount_q;
        pth_pkg::PTH_REG_POINT: datOut_d[12:0] = point_q;
        pth_pkg::PTH_REG_TIMEBASE: begin
          datOut_d[1:0] = bitCounter_q;
          datOut_d[pth_pkg::PTH_TB_DIGIT_LSB +: 4] = digitCounter_q;
          datOut_d[pth_pkg::PTH_TB_SECTOR] = sectorCounter_q;
        end
        pth_pkg::PTH_REG_GLYPH_INDEX: datOut_d[4:0] = busIndex_q;
        pth_pkg::PTH_REG_GLYPH_DATA: datOut_d[19:0] = busGlyph;
        default: datOut_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack_q <= 1'b0;
      datOut_q <= 32'h00000000;
      headEnable_q <= pth_pkg::PTH_CTRL_HEAD_EN_RESET;
      busIndex_q <= 5'h00;
    end else begin
      ack_q <= ack_d;
      datOut_q <= datOut_d;
      headEnable_q <= headEnable_d;
      busIndex_q <= busIndex_d;
    end
  end

  assign wbAck = ack_q;
  assign wbDatOut = datOut_q;
  assign shiftPulses = pulses_q;
  assign pointAtZero = pointZero_q;
  assign pointAtFour = pointFour_q;
  assign headColumnDrive = head_q;
  assign rowTimeSlot = slot_q;

endmodule

// *** test/pth_print_timing_monitor.sv ***
// assertion checker for the print timing and head drive block
`timescale 1ns/100ps
module pth_print_timing_monitor (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // wishbone
  input wire pth_pkg::pth_wb_req_t wbReq,
  input wire logic wbAck,
  input wire logic [31:0] wbDatOut,
  // controller pins
  input wire logic [3:0] timingCommand,
  input wire pth_pkg::pth_entry_t entryRegister,
  input wire pth_pkg::pth_pulses_t shiftPulses,
  input wire logic pointAtZero,
  input wire logic pointAtFour,
  // head
  input wire logic [3:0] headColumnDrive,
  input wire logic [3:0] rowTimeSlot
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_head_idle_off: assert property (!shiftPulses.printStrobe |-> headColumnDrive == 4'h0)
    else $error("head driven outside strobe");
  a_slot_idle_zero: assert property (!shiftPulses.printStrobe |-> rowTimeSlot == 4'h0)
    else $error("row slot outside strobe");
  a_slot_in_range: assert property (shiftPulses.printStrobe |-> rowTimeSlot inside {[4'h1:4'h9]})
    else $error("row slot out of range");
  a_head_upper_rows: assert property (rowTimeSlot > 4'h5 |-> headColumnDrive == 4'h0)
    else $error("head driven past row five");
  a_slot_steps_up: assert property ($rose(shiftPulses.printStrobe) && $past(shiftPulses.printStrobe, 17) |-> rowTimeSlot == 4'h1 [*4] ##1 rowTimeSlot == 4'h2)
    else $error("row slot timing wrong");
  a_char_step_gap: assert property (shiftPulses.charStep |=> !shiftPulses.charStep [*8])
    else $error("char step pulses too close");
  a_point_moves: assert property ($changed(pointAtZero) || $changed(pointAtFour) |-> shiftPulses.pointShift)
    else $error("point moved without pulse");
  a_point_exclusive: assert property (!(pointAtZero && pointAtFour))
    else $error("point at two places");
  a_ack_one_cycle: assert property (wbReq.cyc && wbReq.stb && !wbAck |=> wbAck ##1 !wbAck)
    else $error("ack not a single cycle");
  a_data_idle_zero: assert property (!wbAck |-> wbDatOut == 32'h0)
    else $error("read data without ack");
endmodule
bind pth_print_timing pth_print_timing_monitor mon_u (.clock(clock), .reset(reset), .wbReq(wbReq), .wbAck(wbAck),
  .wbDatOut(wbDatOut), .timingCommand(timingCommand), .entryRegister(entryRegister), .shiftPulses(shiftPulses),
  .pointAtZero(pointAtZero), .pointAtFour(pointAtFour), .headColumnDrive(headColumnDrive), .rowTimeSlot(rowTimeSlot));

// *** test/pth_ctrl_model.sv ***
// control chip stand-in: drives timing command and entry code pins
`timescale 1ns/100ps
module pth_ctrl_model (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // requests from the bench
  input wire logic [3:0] cmdReq,
  input wire pth_pkg::pth_entry_t entryReq,
  // pins toward the block
  output logic [3:0] timingCommand,
  output pth_pkg::pth_entry_t entryRegister
);
  // code goes out with the command so it is settled when the print starts
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      timingCommand <= 4'h0;
      entryRegister <= '0;
    end else begin
      timingCommand <= cmdReq;
      entryRegister <= entryReq;
    end
  end
endmodule

// *** test/pth_print_timing_bench.sv ***
// self-checking bench for the print timing and head drive block
`timescale 1ns/100ps
module pth_print_timing_bench;
  logic clock = 1'b0;
  logic reset = 1'b1;
  pth_pkg::pth_wb_req_t wbReq = '0;
  logic wbAck;
  logic [31:0] wbDatOut;
  logic [3:0] cmdReq = 4'h0;
  pth_pkg::pth_entry_t entryReq = '0;
  logic [3:0] timingCommand;
  pth_pkg::pth_entry_t entryRegister;
  pth_pkg::pth_pulses_t shiftPulses;
  logic pointAtZero;
  logic pointAtFour;
  logic [3:0] headColumnDrive;
  logic [3:0] rowTimeSlot;
  logic [3:0] rowSeen [5];
  logic [31:0] rd;
  logic [19:0] glyph;
  logic [4:0] idx;
  logic [3:0] cmd;
  logic capOn = 1'b0;
  int seed = 20805;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int cnt [4] = '{0, 0, 0, 0};
  int snap [4];
  always #10 clock = ~clock;
  pth_ctrl_model ctrl_u (.clock(clock), .reset(reset), .cmdReq(cmdReq), .entryReq(entryReq),
    .timingCommand(timingCommand), .entryRegister(entryRegister));
  pth_print_timing dut_u (.clock(clock), .reset(reset), .wbReq(wbReq), .wbAck(wbAck), .wbDatOut(wbDatOut),
    .timingCommand(timingCommand), .entryRegister(entryRegister), .shiftPulses(shiftPulses),
    .pointAtZero(pointAtZero), .pointAtFour(pointAtFour), .headColumnDrive(headColumnDrive), .rowTimeSlot(rowTimeSlot));
  always @(posedge clock) begin
    if (!reset) begin
      cnt[0] += shiftPulses.charStep;
      cnt[1] += shiftPulses.printCount;
      cnt[2] += shiftPulses.pointShift;
      cnt[3] += shiftPulses.controlStep;
    end
    if (capOn && shiftPulses.printStrobe && rowTimeSlot inside {[4'h1:4'h5]})
      rowSeen[rowTimeSlot - 4'h1] = headColumnDrive;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      results();
    end
  end
  function automatic logic [3:0] glyphRow(input logic [19:0] g, input int r);
    return g[19 - 4 * r -: 4];
  endfunction
  function automatic logic [12:0] pointExp(input int n);
    return 13'h1 << (n % 13);
  endfunction
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wbCycle(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge clock);
    wbReq <= '{1'b1, 1'b1, we, adr, 4'hf, dat};
    do begin
      @(posedge clock);
      n++;
    end while (wbAck !== 1'b1 && n < 50);
    rd = wbDatOut;
    wbReq <= '0;
    @(posedge clock);
  endtask
  // holds the command through the word end so the step pulses land
  task automatic doPrint(input logic [4:0] i, input logic [19:0] g);
    int n;
    n = 0;
    for (int r = 0; r < 5; r++) rowSeen[r] = 4'hx;
    @(posedge clock);
    entryReq <= '{i[4], i[3:0]};
    cmdReq <= pth_pkg::PTH_CMD_PRINT;
    // first window may start mid-word, so rows come from the next whole one
    while (shiftPulses.printStrobe !== 1'b1 && n < 300) begin
      @(posedge clock);
      n++;
    end
    while (shiftPulses.printStrobe !== 1'b0 && n < 400) begin
      @(posedge clock);
      n++;
    end
    capOn = 1'b1;
    while (shiftPulses.printStrobe !== 1'b1 && n < 500) begin
      @(posedge clock);
      n++;
    end
    while (shiftPulses.printStrobe !== 1'b0 && n < 600) begin
      @(posedge clock);
      n++;
    end
    capOn = 1'b0;
    while (shiftPulses.charStep !== 1'b1 && n < 700) begin
      @(posedge clock);
      n++;
    end
    // one more edge so the tail window steps from slot one into slot two
    @(posedge clock);
    cmdReq <= pth_pkg::PTH_CMD_IDLE;
    repeat (120) @(posedge clock);
    for (int r = 0; r < 5; r++) check("head row", {28'h0, glyphRow(g, r)}, {28'h0, rowSeen[r]});
    wbCycle(1'b0, pth_pkg::PTH_REG_STATUS, 32'h0);
    check("numeric flag", {31'h0, i[4]}, {31'h0, rd[0]});
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    wbCycle(1'b0, pth_pkg::PTH_REG_CTRL, 32'h0);
    check("ctrl reset", 32'h1, rd);
    wbCycle(1'b0, pth_pkg::PTH_REG_POINT, 32'h0);
    check("point reset", 32'h1, rd);
    wbCycle(1'b1, 8'h20, 32'hffffffff);
    wbCycle(1'b0, 8'h20, 32'h0);
    check("unmapped", 32'h0, rd);
    wbCycle(1'b0, pth_pkg::PTH_REG_TIMEBASE, 32'h0);
    glyph = rd[19:0];
    wbCycle(1'b0, pth_pkg::PTH_REG_TIMEBASE, 32'h0);
    check("timebase moving", 32'h1, {31'h0, rd[19:0] !== glyph});
    doPrint(pth_pkg::PTH_IDX_FIVE, 20'hf8e1e);
    doPrint(pth_pkg::PTH_IDX_SIX, 20'h68e96);
    doPrint(pth_pkg::PTH_IDX_E, 20'hf8e8f);
    wbCycle(1'b1, pth_pkg::PTH_REG_GLYPH_INDEX, {27'h0, pth_pkg::PTH_IDX_FIVE});
    wbCycle(1'b0, pth_pkg::PTH_REG_GLYPH_DATA, 32'h0);
    check("fixed glyph", 32'hf8e1e, rd);
    for (int k = 0; k < 3; k++) begin
      idx = 5'($random(seed));
      if (idx inside {pth_pkg::PTH_IDX_FIVE, pth_pkg::PTH_IDX_SIX, pth_pkg::PTH_IDX_E}) idx = idx ^ 5'h01;
      glyph = 20'($random(seed));
      wbCycle(1'b1, pth_pkg::PTH_REG_GLYPH_INDEX, {27'h0, idx});
      wbCycle(1'b1, pth_pkg::PTH_REG_GLYPH_DATA, {12'h0, glyph});
      wbCycle(1'b0, pth_pkg::PTH_REG_GLYPH_DATA, 32'h0);
      check("glyph table", {12'h0, glyph}, rd);
      doPrint(idx, glyph);
    end
    // head disabled: the print runs but no block heats
    wbCycle(1'b1, pth_pkg::PTH_REG_CTRL, 32'h0);
    doPrint(pth_pkg::PTH_IDX_FIVE, 20'h0);
    wbCycle(1'b1, pth_pkg::PTH_REG_CTRL, 32'h1);
    for (int c = 0; c < 7; c++) begin
      cmd = (c < 5) ? 4'((c + 1) % 5) : 4'h6 + 4'($random(seed) & 7);
      snap = cnt;
      @(posedge clock);
      cmdReq <= cmd;
      repeat ((cmd == 4'h3) ? 720 : 120) @(posedge clock);
      cmdReq <= pth_pkg::PTH_CMD_IDLE;
      repeat (60) @(posedge clock);
      for (int k = 0; k < 4; k++) check("pulse seen", {31'h0, cmd == 4'(k + 1)}, {31'h0, cnt[k] != snap[k]});
    end
    wbCycle(1'b0, pth_pkg::PTH_REG_CHAR_STEP, 32'h0);
    check("char step count", {27'h0, cnt[0][4:0]}, rd);
    wbCycle(1'b0, pth_pkg::PTH_REG_PRINT_COUNT, 32'h0);
    check("print count", {22'h0, cnt[1][9:0]}, rd);
    wbCycle(1'b0, pth_pkg::PTH_REG_POINT, 32'h0);
    check("point register", {19'h0, pointExp(cnt[2])}, rd);
    check("point at zero", {31'h0, cnt[2] % 13 == 0}, {31'h0, pointAtZero});
    check("point at four", {31'h0, cnt[2] % 13 == 4}, {31'h0, pointAtFour});
    results();
  end
endmodule
